/* pkg/regfile_pkg.sv */
package regfile_pkg;

	// ----------------------------------------------------------------
	// Sizes and register indices
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned REG_COUNT = 16;
	localparam int unsigned IDX_W     = 4;
	localparam logic [3:0]  PC_IDX    = 4'h0;
	localparam logic [3:0]  SP_IDX    = 4'h1;
	localparam logic [3:0]  SR_IDX    = 4'h2;
	localparam logic [3:0]  CG_IDX    = 4'h3;

	// ----------------------------------------------------------------
	// Reset values and step sizes
	// ----------------------------------------------------------------
	localparam logic [15:0] PC_RESET  = 16'h0000;
	localparam logic [15:0] SP_RESET  = 16'h0000;
	localparam logic [15:0] GPR_RESET = 16'h0000;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] EVEN_MASK = 16'hfffe;

	// ----------------------------------------------------------------
	// Commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LEN_TWO,
		LEN_FOUR,
		LEN_SIX,
		LEN_NONE
	} instr_len_t;

	typedef enum logic [1:0] {
		STK_NONE,
		STK_PUSH,
		STK_POP
	} stack_op_t;

	// Register file request from the execution unit, one per cycle.
	typedef struct packed {
		logic [3:0]  rd_a_idx;
		logic [3:0]  rd_b_idx;
		logic        wr_en;
		logic [3:0]  wr_idx;
		logic        wr_byte;
		logic [15:0] wr_data;
		instr_len_t  advance;
		stack_op_t   stack_op;
		logic        pop_to_sp;
	} rf_req_t;

	// Memory bus request.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        byte_en;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

endpackage

/* src/reg_bank.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Working register bank, registers four to fifteen
// ----------------------------------------------------------------
module reg_bank #(
	parameter int unsigned WIDTH = regfile_pkg::DATA_W,
	parameter int unsigned COUNT = regfile_pkg::REG_COUNT
) (
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	input  wire logic              i_wr_en,
	input  wire logic [3:0]        i_wr_idx,
	input  wire logic              i_wr_byte,
	input  wire logic [WIDTH-1:0]  i_wr_data,
	input  wire logic [3:0]        i_rd_a_idx,
	input  wire logic [3:0]        i_rd_b_idx,
	output logic      [WIDTH-1:0]  o_rd_a,
	output logic      [WIDTH-1:0]  o_rd_b
);

	typedef struct packed {
		logic [COUNT-1:0][WIDTH-1:0] regs;
	} bank_state_t;

	bank_state_t state_ff;
	bank_state_t nxt_state;

	// Byte writes clear the upper half, word writes store the whole value.
	always_comb begin
		nxt_state = state_ff;
		for (int i = 4; i < COUNT; i++) begin
			if (i_wr_en && (i_wr_idx == 4'(i))) begin
				if (i_wr_byte) begin
					nxt_state.regs[i] = {8'h00, i_wr_data[7:0]};
				end else begin
					nxt_state.regs[i] = i_wr_data;
				end
			end
		end
		if (!i_resetn) begin
			nxt_state.regs = '0;
		end
	end

	// The bank registers on every edge.
	always_ff @(posedge i_clock) begin
		state_ff <= nxt_state;
	end

	// Read ports are combinational so register operands arrive the same cycle.
	assign o_rd_a = state_ff.regs[i_rd_a_idx];
	assign o_rd_b = state_ff.regs[i_rd_b_idx];

endmodule

/* src/cpu_pc_sp_register_file.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Program counter, stack pointer and register file of the core
// ----------------------------------------------------------------
module cpu_pc_sp_register_file (
	input  wire logic                 i_clock,
	input  wire logic                 i_resetn,
	input  wire regfile_pkg::rf_req_t i_req,
	input  wire logic                 i_push_byte,
	input  wire logic [15:0]          i_mem_rdata,
	output regfile_pkg::mem_req_t     o_fetch,
	output regfile_pkg::mem_req_t     o_stack,
	output logic [15:0]               o_rd_a,
	output logic [15:0]               o_rd_b,
	output logic [15:0]               o_pc,
	output logic [15:0]               o_sp
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic        fetch_valid;
		logic        stk_valid;
		logic        stk_write;
		logic        stk_byte;
		logic [15:0] stk_addr;
		logic [15:0] stk_wdata;
	} core_state_t;

	core_state_t state_ff;
	core_state_t nxt_state;

	logic [15:0] bank_a;
	logic [15:0] bank_b;
	logic [15:0] step;
	logic [15:0] pushed_value;
	logic        is_gpr_a;
	logic        is_gpr_b;

	// Working registers live in a separate bank.
	reg_bank #(
		.WIDTH (regfile_pkg::DATA_W),
		.COUNT (regfile_pkg::REG_COUNT)
	) u_bank (
		.i_clock    (i_clock),
		.i_resetn   (i_resetn),
		.i_wr_en    (i_req.wr_en),
		.i_wr_idx   (i_req.wr_idx),
		.i_wr_byte  (i_req.wr_byte),
		.i_wr_data  (i_req.wr_data),
		.i_rd_a_idx (i_req.rd_a_idx),
		.i_rd_b_idx (i_req.rd_b_idx),
		.o_rd_a     (bank_a),
		.o_rd_b     (bank_b)
	);

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	// Registers two and three read as zero here; their duties lie elsewhere.
	assign is_gpr_a = (i_req.rd_a_idx > regfile_pkg::CG_IDX);
	assign is_gpr_b = (i_req.rd_b_idx > regfile_pkg::CG_IDX);

	// Operand A selection across all sixteen registers.
	always_comb begin
		if (i_req.rd_a_idx == regfile_pkg::PC_IDX) begin
			o_rd_a = state_ff.pc;
		end else if (i_req.rd_a_idx == regfile_pkg::SP_IDX) begin
			o_rd_a = state_ff.sp;
		end else if (is_gpr_a) begin
			o_rd_a = bank_a;
		end else begin
			o_rd_a = 16'h0000;
		end
	end

	// Operand B selection across all sixteen registers.
	always_comb begin
		if (i_req.rd_b_idx == regfile_pkg::PC_IDX) begin
			o_rd_b = state_ff.pc;
		end else if (i_req.rd_b_idx == regfile_pkg::SP_IDX) begin
			o_rd_b = state_ff.sp;
		end else if (is_gpr_b) begin
			o_rd_b = bank_b;
		end else begin
			o_rd_b = 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Instruction length in bytes.
	always_comb begin
		unique case (i_req.advance)
			regfile_pkg::LEN_TWO:  step = 16'h0002;
			regfile_pkg::LEN_FOUR: step = 16'h0004;
			regfile_pkg::LEN_SIX:  step = 16'h0006;
			regfile_pkg::LEN_NONE: step = 16'h0000;
		endcase
	end

	// A push of the stack pointer stores its value before the decrement.
	assign pushed_value = state_ff.sp;

	// Sequence program counter and stack pointer, and issue bus requests.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.fetch_valid = 1'b1;
		nxt_state.stk_valid = 1'b0;
		nxt_state.stk_write = 1'b0;
		nxt_state.stk_byte = 1'b0;
		// Program counter advances by the length, or branches on a write.
		if (i_req.wr_en && i_req.wr_idx == regfile_pkg::PC_IDX) begin
			nxt_state.pc = i_req.wr_data & regfile_pkg::EVEN_MASK;
		end else begin
			nxt_state.pc = state_ff.pc + step;
		end
		// Stack pointer updates from software writes and stack operations.
		if (i_req.stack_op == regfile_pkg::STK_PUSH) begin
			nxt_state.sp = (state_ff.sp - regfile_pkg::WORD_STEP);
			nxt_state.stk_valid = 1'b1;
			nxt_state.stk_write = 1'b1;
			nxt_state.stk_byte = i_push_byte;
			nxt_state.stk_addr = state_ff.sp - regfile_pkg::WORD_STEP;
			if (i_req.rd_a_idx == regfile_pkg::SP_IDX) begin
				nxt_state.stk_wdata = pushed_value;
			end else begin
				nxt_state.stk_wdata = o_rd_a;
			end
		end else if (i_req.stack_op == regfile_pkg::STK_POP) begin
			nxt_state.stk_valid = 1'b1;
			nxt_state.stk_addr = state_ff.sp;
			if (i_req.pop_to_sp) begin
				nxt_state.sp = i_mem_rdata & regfile_pkg::EVEN_MASK;
			end else begin
				nxt_state.sp = state_ff.sp + regfile_pkg::WORD_STEP;
			end
		end else if (i_req.wr_en && i_req.wr_idx == regfile_pkg::SP_IDX) begin
			nxt_state.sp = i_req.wr_data & regfile_pkg::EVEN_MASK;
		end
		if (!i_resetn) begin
			nxt_state = '0;
			nxt_state.pc = regfile_pkg::PC_RESET;
			nxt_state.sp = regfile_pkg::SP_RESET;
		end
	end

	// All state registers on every edge.
	always_ff @(posedge i_clock) begin
		state_ff <= nxt_state;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Fetch address is the program counter, always a whole word.
	always_comb begin
		o_fetch.valid = state_ff.fetch_valid;
		o_fetch.write = 1'b0;
		o_fetch.byte_en = 1'b0;
		o_fetch.addr = state_ff.pc;
		o_fetch.wdata = 16'h0000;
	end

	// Stack bus request registered from the previous cycle.
	always_comb begin
		o_stack.valid = state_ff.stk_valid;
		o_stack.write = state_ff.stk_write;
		o_stack.byte_en = state_ff.stk_byte;
		o_stack.addr = state_ff.stk_addr;
		o_stack.wdata = state_ff.stk_wdata;
	end

	assign o_pc = state_ff.pc;
	assign o_sp = state_ff.sp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Reset returns the counters and both bus requests to their start values.
	a_reset_state: assert property (@(posedge i_clock)
		!i_resetn |=>
		(o_pc == regfile_pkg::PC_RESET) && (o_sp == regfile_pkg::SP_RESET)
		&& !o_stack.valid && !o_fetch.valid)
		else $error("Registers not at their start values after reset.");

	// Fetching begins one cycle after reset is released and then never pauses.
	a_fetch_valid: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_fetch.valid)
		else $error("Fetch request missing after reset.");

	// ----------------------------------------------------------------
	// Program counter checks
	// ----------------------------------------------------------------
	// The program counter stays on word boundaries whatever is written into it.
	a_pc_even: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_pc[0] == 1'b0)
		else $error("Program counter is odd.");

	// Each instruction length moves the program counter by exactly that many bytes.
	a_pc_two: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(!(i_req.wr_en && i_req.wr_idx == regfile_pkg::PC_IDX)
		&& i_req.advance == regfile_pkg::LEN_TWO)
		|=> (o_pc == $past(o_pc) + 16'h0002))
		else $error("PC did not advance by two.");

	a_pc_advance: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(!(i_req.wr_en && i_req.wr_idx == 4'h0)
		&& i_req.advance == regfile_pkg::LEN_FOUR)
		|=> (o_pc == $past(o_pc) + 16'h0004))
		else $error("PC did not advance by four.");

	a_pc_six: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(!(i_req.wr_en && i_req.wr_idx == regfile_pkg::PC_IDX)
		&& i_req.advance == regfile_pkg::LEN_SIX)
		|=> (o_pc == $past(o_pc) + 16'h0006))
		else $error("PC did not advance by six.");

	// With no length given and no write, the program counter holds its value.
	a_pc_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(!(i_req.wr_en && i_req.wr_idx == regfile_pkg::PC_IDX)
		&& i_req.advance == regfile_pkg::LEN_NONE)
		|=> (o_pc == $past(o_pc)))
		else $error("PC moved without an instruction length.");

	// A write into the program counter is a branch to the written even address.
	a_pc_branch: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.wr_en && i_req.wr_idx == 4'h0)
		|=> (o_pc == ($past(i_req.wr_data) & 16'hfffe)))
		else $error("PC write did not branch.");

	// ----------------------------------------------------------------
	// Stack pointer checks
	// ----------------------------------------------------------------
	// Written and popped pointer values lose bit zero, so the pointer stays even.
	a_sp_even: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_sp[0] == 1'b0)
		else $error("Stack pointer is odd.");

	// A push lowers the pointer first and writes at the lowered address.
	a_push_predec: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_PUSH) |=>
		(o_sp == $past(o_sp) - 16'h0002) && o_stack.write && (o_stack.addr == o_sp))
		else $error("Push did not predecrement.");

	// A plain pop reads at the old pointer and raises it afterwards.
	a_pop_postinc: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_POP && !i_req.pop_to_sp) |=>
		(o_sp == $past(o_sp) + 16'h0002) && (o_stack.addr == $past(o_sp)))
		else $error("Pop did not postincrement.");

	// A pop is a word read on the bus, never a write or a byte access.
	a_pop_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_POP) |=>
		o_stack.valid && !o_stack.write && !o_stack.byte_en)
		else $error("Pop was not a word read.");

	// Popping into the stack pointer takes the popped word with no increment.
	a_pop_to_sp: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_POP && i_req.pop_to_sp) |=>
		(o_sp == ($past(i_mem_rdata) & 16'hfffe)))
		else $error("Pop into SP wrong.");

	// Pushing the stack pointer stores the value it had before the push.
	a_push_sp_old: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_PUSH && i_req.rd_a_idx == 4'h1) |=>
		(o_stack.wdata == $past(o_sp)))
		else $error("Push of SP stored new value.");

	// A byte push reaches the bus marked as a byte access.
	a_byte_push: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_PUSH && i_push_byte) |=>
		o_stack.byte_en)
		else $error("Byte push not marked as byte.");

	// A stack request on the bus always follows a push or a pop one cycle earlier.
	a_stack_pulse: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_stack.valid |-> ($past(i_req.stack_op) != regfile_pkg::STK_NONE))
		else $error("Stack request without a stack operation.");

	// Software writes reach the stack pointer when no stack operation competes.
	a_sp_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_NONE && i_req.wr_en && i_req.wr_idx == 4'h1)
		|=> (o_sp == ($past(i_req.wr_data) & 16'hfffe)))
		else $error("SP write lost.");

	// Without a stack operation or a write the stack pointer holds.
	a_sp_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.stack_op == regfile_pkg::STK_NONE
		&& !(i_req.wr_en && i_req.wr_idx == regfile_pkg::SP_IDX))
		|=> (o_sp == $past(o_sp)))
		else $error("Stack pointer changed on its own.");

	// ----------------------------------------------------------------
	// Register file checks
	// ----------------------------------------------------------------
	// A word written to a working register reads back on the very next cycle.
	a_gpr_single: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.wr_en && !i_req.wr_byte && is_gpr_a && i_req.rd_a_idx == i_req.wr_idx)
		|=> (i_req.rd_a_idx != $past(i_req.wr_idx)) || (o_rd_a == $past(i_req.wr_data)))
		else $error("Register write not visible next cycle.");

	// Registers two and three hold nothing here and read as zero on both ports.
	a_res_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.rd_a_idx == regfile_pkg::SR_IDX || i_req.rd_a_idx == regfile_pkg::CG_IDX)
		|-> (o_rd_a == 16'h0000))
		else $error("Register two or three read nonzero on port A.");

	a_res_zero_b: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.rd_b_idx == regfile_pkg::SR_IDX || i_req.rd_b_idx == regfile_pkg::CG_IDX)
		|-> (o_rd_b == 16'h0000))
		else $error("Register two or three read nonzero on port B.");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	// Main scenarios: pushes, plain pops, pops into the pointer, byte pushes, branches.
	c_push: cover property (@(posedge i_clock) i_req.stack_op == regfile_pkg::STK_PUSH);
	c_pop_sp: cover property (@(posedge i_clock)
		i_req.stack_op == regfile_pkg::STK_POP && i_req.pop_to_sp);
	c_branch: cover property (@(posedge i_clock) i_req.wr_en && i_req.wr_idx == 4'h0);
	c_pop_plain: cover property (@(posedge i_clock)
		i_req.stack_op == regfile_pkg::STK_POP && !i_req.pop_to_sp);
	c_byte_push: cover property (@(posedge i_clock)
		i_req.stack_op == regfile_pkg::STK_PUSH && i_push_byte);

endmodule

/* dv/stack_mem_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Data memory model behind the stack port
// ----------------------------------------------------------------
module stack_mem_model (
	input  wire logic                  i_clock,
	input  wire regfile_pkg::mem_req_t i_stack,
	input  wire logic [15:0]           i_sp,
	input  wire logic                  i_pop,
	output logic      [15:0]           o_rdata
);
	logic [15:0] mem_ff [256];
	logic [15:0] last_ff = 16'h0000;

	// Stores pushed words; a byte push only changes the low byte.
	always_ff @(posedge i_clock) begin
		if (i_stack.valid && i_stack.write) begin
			if (i_stack.byte_en) begin
				mem_ff[i_stack.addr[8:1]][7:0] <= i_stack.wdata[7:0];
			end else begin
				mem_ff[i_stack.addr[8:1]] <= i_stack.wdata;
			end
		end
		last_ff <= o_rdata;
	end

	// Gives the top of stack during a pop and a toggling pattern otherwise.
	assign o_rdata = i_pop ? mem_ff[i_sp[8:1]] : ~last_ff;
endmodule

/* dv/tb_cpu_pc_sp_register_file.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench for the register file
// ----------------------------------------------------------------
module tb_cpu_pc_sp_register_file;
	logic                  i_clock;
	logic                  i_resetn;
	regfile_pkg::rf_req_t  req;
	regfile_pkg::rf_req_t  idle;
	logic                  push_byte;
	logic [15:0]           mem_rdata;
	regfile_pkg::mem_req_t fetch;
	regfile_pkg::mem_req_t stack;
	logic [15:0]           rd_a;
	logic [15:0]           rd_b;
	logic [15:0]           pc;
	logic [15:0]           sp;
	int                    n_fail;
	int                    compares;
	int                    cycles;
	logic [15:0]           exp_pc;

	cpu_pc_sp_register_file i_dut (
		.i_clock     (i_clock),
		.i_resetn    (i_resetn),
		.i_req       (req),
		.i_push_byte (push_byte),
		.i_mem_rdata (mem_rdata),
		.o_fetch     (fetch),
		.o_stack     (stack),
		.o_rd_a      (rd_a),
		.o_rd_b      (rd_b),
		.o_pc        (pc),
		.o_sp        (sp)
	);

	stack_mem_model i_mem (
		.i_clock (i_clock),
		.i_stack (stack),
		.i_sp    (sp),
		.i_pop   (req.stack_op == regfile_pkg::STK_POP),
		.o_rdata (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial i_clock = 1'b0;
	always #5 i_clock = ~i_clock;

	// Cuts a hung run short after far more cycles than the tests need.
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Presents one request for one edge, then idles with the same read selects.
	task automatic run(input regfile_pkg::rf_req_t r);
		regfile_pkg::rf_req_t hold;
		hold = idle;
		hold.rd_a_idx = r.rd_a_idx;
		hold.rd_b_idx = r.rd_b_idx;
		@(posedge i_clock);
		req <= r;
		@(posedge i_clock);
		req <= hold;
		#1;
	endtask

	// Selects two operands and compares the combinational reads.
	task automatic rd(input logic [3:0] a, input logic [3:0] b,
			input logic [15:0] ea, input logic [15:0] eb);
		regfile_pkg::rf_req_t r;
		r = idle;
		r.rd_a_idx = a;
		r.rd_b_idx = b;
		@(posedge i_clock);
		req <= r;
		#1;
		check(rd_a, ea);
		check(rd_b, eb);
	endtask

	function automatic regfile_pkg::rf_req_t wreq(input logic [3:0] idx,
			input logic [15:0] d, input logic bytew);
		regfile_pkg::rf_req_t r;
		r = idle;
		r.wr_en = 1'b1;
		r.wr_idx = idx;
		r.wr_data = d;
		r.wr_byte = bytew;
		r.rd_a_idx = idx;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		@(posedge i_clock);
		#1;
		check(pc, regfile_pkg::PC_RESET);
		check(sp, regfile_pkg::SP_RESET);
		check({15'h0000, fetch.valid}, 16'h0001);
		check(fetch.addr, exp_pc);
	endtask

	task automatic t_advance();
		regfile_pkg::rf_req_t r;
		logic [15:0] steps [4] = '{16'h0002, 16'h0004, 16'h0006, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			r = idle;
			r.advance = regfile_pkg::instr_len_t'(i);
			run(r);
			exp_pc = exp_pc + steps[i];
			check(pc, exp_pc);
			check(fetch.addr, exp_pc);
		end
	endtask

	task automatic t_branch();
		regfile_pkg::rf_req_t r;
		r = wreq(regfile_pkg::PC_IDX, 16'h2345, 1'b0);
		r.advance = regfile_pkg::LEN_SIX;
		run(r);
		exp_pc = 16'h2344;
		check(pc, exp_pc);
		check(fetch.addr, exp_pc);
		rd(regfile_pkg::PC_IDX, regfile_pkg::PC_IDX, exp_pc, exp_pc);
	endtask

	task automatic t_bank();
		for (int i = 4; i < 16; i++) begin
			run(wreq(4'(i), 16'(i) * 16'h1111, 1'b0));
			check(rd_a, 16'(i) * 16'h1111);
			rd(4'(i), 4'(i), 16'(i) * 16'h1111, 16'(i) * 16'h1111);
		end
		run(wreq(regfile_pkg::SR_IDX, 16'hffff, 1'b0));
		run(wreq(regfile_pkg::CG_IDX, 16'hffff, 1'b0));
		rd(regfile_pkg::SR_IDX, regfile_pkg::CG_IDX, 16'h0000, 16'h0000);
		rd(4'h4, 4'hf, 16'h4444, 16'hffff);
		run(wreq(4'h7, 16'h5aa5, 1'b1));
		rd(4'h7, 4'h6, 16'h00a5, 16'h6666);
	endtask

	task automatic t_stack();
		regfile_pkg::rf_req_t r;
		run(wreq(regfile_pkg::SP_IDX, 16'h0400, 1'b0));
		check(sp, 16'h0400);
		rd(regfile_pkg::SP_IDX, 4'h5, 16'h0400, 16'h5555);
		run(wreq(4'h5, 16'h1234, 1'b0));
		r = idle;
		r.stack_op = regfile_pkg::STK_PUSH;
		r.rd_a_idx = 4'h5;
		run(r);
		check(sp, 16'h03fe);
		check(stack.addr, 16'h03fe);
		check(stack.wdata, 16'h1234);
		check({stack.valid, stack.write, stack.byte_en, 13'h0000}, 16'hc000);
		r.rd_a_idx = regfile_pkg::SP_IDX;
		run(r);
		check(sp, 16'h03fc);
		check(stack.wdata, 16'h03fe);
		r = idle;
		r.stack_op = regfile_pkg::STK_POP;
		run(r);
		check(sp, 16'h03fe);
		check(stack.addr, 16'h03fc);
		check({stack.valid, stack.write, stack.byte_en, 13'h0000}, 16'h8000);
		r.pop_to_sp = 1'b1;
		run(r);
		check(sp, 16'h1234);
		@(posedge i_clock);
		push_byte <= 1'b1;
		r = idle;
		r.stack_op = regfile_pkg::STK_PUSH;
		r.rd_a_idx = 4'h5;
		run(r);
		check({stack.valid, stack.write, stack.byte_en, 13'h0000}, 16'he000);
		check(stack.addr, 16'h1232);
		@(posedge i_clock);
		push_byte <= 1'b0;
	endtask

	// Pulls reset again in mid-run and checks that PC, SP, both bus requests and registers five and fifteen start over.
	task automatic t_rereset();
		@(posedge i_clock);
		i_resetn <= 1'b0;
		repeat (5) @(posedge i_clock);
		i_resetn <= 1'b1;
		#1;
		exp_pc = regfile_pkg::PC_RESET;
		check(pc, exp_pc);
		check(sp, regfile_pkg::SP_RESET);
		check({15'h0000, fetch.valid}, 16'h0000);
		check({15'h0000, stack.valid}, 16'h0000);
		rd(4'h5, 4'hf, regfile_pkg::GPR_RESET, regfile_pkg::GPR_RESET);
		check({15'h0000, fetch.valid}, 16'h0001);
		check(fetch.addr, exp_pc);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		idle = '0;
		idle.advance = regfile_pkg::LEN_NONE;
		req = idle;
		i_resetn = 1'b0;
		push_byte = 1'b0;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		exp_pc = regfile_pkg::PC_RESET;
		repeat (5) @(posedge i_clock);
		i_resetn <= 1'b1;
		t_reset();
		t_advance();
		t_branch();
		t_bank();
		t_stack();
		t_rereset();
		give_verdict();
	end
endmodule
